// [logic/pot_spi_defs.vh]
`ifndef POT_SPI_DEFS_VH
`define POT_SPI_DEFS_VH

// Two-bit command codes as they follow the address field
`define CMD_WRITE          2'h0
`define CMD_INC            2'h1
`define CMD_DEC            2'h2
`define CMD_READ           2'h3

// Memory map
`define ADDR_WIPER0        4'h0
`define ADDR_WIPER1        4'h1
`define ADDR_STATUS        4'h4
`define ADDR_TERM_CTRL     4'h5

// Status register layout
`define STATUS_WA_BIT      0

// Reset values
`define WIPER_RESET        9'h080
`define TERM_CTRL_RESET    9'h1ff
`define MEM_RESET          9'h000

// Wiper full scale
`define FULL_SCALE_8BIT    9'h100
`define FULL_SCALE_7BIT    9'h080

// Clock counts within one command
`define CLK_DECODE         5'd6
`define CLK_ERR            5'd7
`define CLK_INC            5'd8
`define CLK_FULL           5'd16

// Timing
`define CLOCK_PERIOD_NS    10
`define NV_WRITE_CYCLE_NS  5000000

`endif

// [logic/sync2.v]
`timescale 1ns/1ps
module sync2 #(
   parameter WIDTH     = 1,
   parameter RESET_VAL = 0
) (
   input  wire             clock,
   input  wire             rstn,
   input  wire [WIDTH-1:0] din,
   output wire [WIDTH-1:0] dout
);
   reg [WIDTH-1:0] meta_r;
   reg [WIDTH-1:0] sync_r;

   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         meta_r <= RESET_VAL[WIDTH-1:0];
         sync_r <= RESET_VAL[WIDTH-1:0];
      end else begin
         meta_r <= din;
         sync_r <= meta_r;
      end
   end

   assign dout = sync_r;
endmodule

// [logic/pot_spi_command_engine.v]
// Summary of operation
// - Non-volatile write starts only at chip-select release after exactly 16 clocks.
// - Chip select may be reasserted at once; a new transaction is accepted.
// - During a write cycle only addresses 00h,01h,04h,05h are accepted.
// - Status register at 04h shows the write-active flag.
// - Any command after a non-volatile write in one select period is an error.
// - Back-to-back writes in one select period allowed to volatile addresses.
// - Consecutive non-volatile writes in one select period raise the error.
// - Read decodes six bits, drives error bit at clock 7, then 9 data bits.
// - Reads accepted for volatile and non-volatile locations.
// - Back-to-back reads to any location within one select period.
// - Increment is 8 clocks, wipers only, applied at the eighth clock.
// - Increment saturates at full scale.
// - Wiper above full scale is not incremented.
// - Increment drives the error bit on SDO at clock 7.
// - Increment accepted fresh or following a previous command in the string.
// - Volatile write applied once all 16 bits arrive; shorter frames do nothing.
`timescale 1ns/1ps
`include "pot_spi_defs.vh"
module pot_spi_command_engine #(
   parameter [8:0] FULL_SCALE      = `FULL_SCALE_8BIT,
   parameter       NV_WRITE_CYCLES = `NV_WRITE_CYCLE_NS / `CLOCK_PERIOD_NS
) (
   input  wire       clock,
   input  wire       rstn,
   input  wire       cs_n,
   input  wire       sck,
   input  wire       sdi,
   output wire       sdo,
   output wire       sdo_oe_n,
   output wire [8:0] wiper0,
   output wire [8:0] wiper1,
   output wire [8:0] terminal_connect_control,
   output wire       nv_write_active
);
   wire [2:0]  pins_s;
   wire        cs_n_s;
   wire        sck_s;
   wire        sdi_s;
   reg         sck_prev_r;
   reg         cs_act_prev_r;
   reg  [8:0]  mem_r [0:15];
   reg  [15:0] shift_r;
   reg  [4:0]  bit_cnt_r;
   reg  [3:0]  addr_r;
   reg  [1:0]  cmd_r;
   reg  [8:0]  rdata_r;
   reg         err_r;
   reg         sdo_r;
   reg         nv_pend_r;
   reg  [3:0]  nv_addr_r;
   reg  [8:0]  nv_data_r;
   reg         busy_r;
   reg  [31:0] nv_cnt_r;
   wire        cs_act;
   wire        sck_rise;
   wire        cs_release;
   wire [15:0] shift_nxt;
   wire [4:0]  cnt_nxt;
   wire [3:0]  dec_addr;
   wire [1:0]  dec_cmd;
   wire [8:0]  inc_val;
   integer     i;

   sync2 #(
      .WIDTH     (3),
      .RESET_VAL (5)
   ) u_sync (
      .clock (clock),
      .rstn  (rstn),
      .din   ({cs_n, sck, sdi}),
      .dout  (pins_s)
   );

   assign cs_n_s = pins_s[2];
   assign sck_s  = pins_s[1];
   assign sdi_s  = pins_s[0];

   function is_volatile;
      input [3:0] a;
      begin
         is_volatile = (a == `ADDR_WIPER0) || (a == `ADDR_WIPER1) ||
                       (a == `ADDR_STATUS) || (a == `ADDR_TERM_CTRL);
      end
   endfunction

   function is_wiper;
      input [3:0] a;
      begin
         is_wiper = (a == `ADDR_WIPER0) || (a == `ADDR_WIPER1);
      end
   endfunction

   // Status is built from live state so polling sees the cycle end at once
   function [8:0] read_value;
      input [3:0] a;
      input [8:0] m;
      input       b;
      begin
         if (a == `ADDR_STATUS) begin
            read_value = 9'h000;
            read_value[`STATUS_WA_BIT] = b;
         end else begin
            read_value = m;
         end
      end
   endfunction

   function cmd_invalid;
      input [3:0] a;
      input [1:0] c;
      input       busy;
      input       pend;
      begin
         cmd_invalid = pend ||
                       (busy && !is_volatile(a)) ||
                       (c == `CMD_DEC) ||
                       ((c == `CMD_INC) && !is_wiper(a));
      end
   endfunction

   assign cs_act     = ~cs_n_s;
   assign sck_rise   = sck_s & ~sck_prev_r;
   assign cs_release = cs_act_prev_r & ~cs_act;
   assign shift_nxt  = {shift_r[14:0], sdi_s};
   assign cnt_nxt    = bit_cnt_r + 5'd1;
   assign dec_addr   = shift_nxt[5:2];
   assign dec_cmd    = shift_nxt[1:0];
   // Reserved values above full scale are left alone as well
   assign inc_val    = (mem_r[addr_r] < FULL_SCALE) ? mem_r[addr_r] + 9'h001 : mem_r[addr_r];

   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         sck_prev_r    <= 1'b0;
         cs_act_prev_r <= 1'b0;
         shift_r       <= 16'h0000;
         bit_cnt_r     <= 5'h00;
         addr_r        <= 4'h0;
         cmd_r         <= 2'h0;
         rdata_r       <= 9'h000;
         err_r         <= 1'b0;
         sdo_r         <= 1'b1;
         nv_pend_r     <= 1'b0;
         nv_addr_r     <= 4'h0;
         nv_data_r     <= 9'h000;
         busy_r        <= 1'b0;
         nv_cnt_r      <= 32'h00000000;
         for (i = 0; i < 16; i = i + 1) begin
            mem_r[i] <= `MEM_RESET;
         end
         mem_r[`ADDR_WIPER0] <= `WIPER_RESET;
         mem_r[`ADDR_WIPER1] <= `WIPER_RESET;
         mem_r[`ADDR_TERM_CTRL] <= `TERM_CTRL_RESET;
      end else begin
         sck_prev_r    <= sck_s;
         cs_act_prev_r <= cs_act;

         // Non-volatile cycle runs independent of the serial port
         if (busy_r) begin
            if (nv_cnt_r == 32'h00000000) begin
               busy_r           <= 1'b0;
               mem_r[nv_addr_r] <= nv_data_r;
            end else begin
               nv_cnt_r <= nv_cnt_r - 32'h00000001;
            end
         end

         if (cs_release) begin
            // Frame state clears here so a new select starts clean
            bit_cnt_r <= 5'h00;
            err_r     <= 1'b0;
            sdo_r     <= 1'b1;
            nv_pend_r <= 1'b0;
            if (nv_pend_r && (bit_cnt_r == 5'h00) && !err_r) begin
               busy_r   <= 1'b1;
               nv_cnt_r <= NV_WRITE_CYCLES - 1;
            end
         end else if (cs_act && sck_rise) begin
            shift_r   <= shift_nxt;
            bit_cnt_r <= cnt_nxt;
            if (!err_r) begin
               if (cnt_nxt == `CLK_DECODE) begin
                  addr_r  <= dec_addr;
                  cmd_r   <= dec_cmd;
                  rdata_r <= read_value(dec_addr, mem_r[dec_addr], busy_r);
                  if (cmd_invalid(dec_addr, dec_cmd, busy_r, nv_pend_r)) begin
                     err_r <= 1'b1;
                     sdo_r <= 1'b0;
                  end else begin
                     sdo_r <= 1'b1;
                  end
               end else if ((cmd_r == `CMD_READ) && (cnt_nxt >= `CLK_ERR) && (cnt_nxt < `CLK_FULL)) begin
                  sdo_r   <= rdata_r[8];
                  rdata_r <= {rdata_r[7:0], 1'b0};
               end else if ((cmd_r == `CMD_INC) && (cnt_nxt == `CLK_INC)) begin
                  mem_r[addr_r] <= inc_val;
                  bit_cnt_r     <= 5'h00;
                  sdo_r         <= 1'b1;
               end else if (cnt_nxt == `CLK_FULL) begin
                  bit_cnt_r <= 5'h00;
                  sdo_r     <= 1'b1;
                  if (cmd_r == `CMD_WRITE) begin
                     if (is_volatile(addr_r)) begin
                        // Status is read-only; a write to it is accepted and dropped
                        if (addr_r != `ADDR_STATUS) begin
                           mem_r[addr_r] <= shift_nxt[8:0];
                        end
                     end else begin
                        nv_pend_r <= 1'b1;
                        nv_addr_r <= addr_r;
                        nv_data_r <= shift_nxt[8:0];
                     end
                  end
               end
            end else if (cnt_nxt == `CLK_FULL) begin
               // Keep counting under error so a later release sees the length
               bit_cnt_r <= 5'h00;
            end
         end
      end
   end

   assign sdo                      = sdo_r;
   assign sdo_oe_n                 = cs_n_s;
   assign wiper0                   = mem_r[`ADDR_WIPER0];
   assign wiper1                   = mem_r[`ADDR_WIPER1];
   assign terminal_connect_control = mem_r[`ADDR_TERM_CTRL];
   assign nv_write_active          = busy_r;
endmodule

// [testbench/pot_spi_command_engine_asserts.sv]
`timescale 1ns/1ps
module pot_spi_command_engine_checks #(
   parameter [8:0] FULL_SCALE      = 9'h100,
   parameter       NV_WRITE_CYCLES = 500000
) (
   input wire logic       clock,
   input wire logic       rstn,
   input wire logic       cs_n,
   input wire logic       sck,
   input wire logic       sdi,
   input wire logic       sdo,
   input wire logic       sdo_oe_n,
   input wire logic [8:0] wiper0,
   input wire logic [8:0] wiper1,
   input wire logic [8:0] terminal_connect_control,
   input wire logic       nv_write_active
);
   logic [31:0] run_r;
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         run_r <= 32'h0;
      end else begin
         run_r <= nv_write_active ? run_r + 32'h1 : 32'h0;
      end
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);
   // Pin rise passes two sync flops, so any update lags it by three samples
   sequence sck_seen;
      $past(sck, 3) && !$past(cs_n, 3);
   endsequence
   sequence nv_start;
      $rose(nv_write_active);
   endsequence
   // A host may reselect at once, so look back to the samples that saw the release
   AST_NV_AFTER_RELEASE: assert property (nv_start |-> $past(cs_n, 3)) else $error("write cycle without release");
   AST_NV_NOT_SELECTED: assert property (nv_start |-> $past(sdo_oe_n)) else $error("write cycle while selected");
   AST_NV_LENGTH: assert property ($fell(nv_write_active) |-> run_r == NV_WRITE_CYCLES) else $error("busy length");
   AST_SDO_IDLE: assert property (sdo_oe_n [*3] |-> sdo) else $error("sdo low while idle");
   AST_SDO_ON_SCK: assert property ($changed(sdo) && !sdo_oe_n |-> sck_seen) else $error("sdo moved without sck");
   AST_W0_ON_SCK: assert property ($changed(wiper0) |-> sck_seen) else $error("wiper0 moved without sck");
   AST_W1_ON_SCK: assert property ($changed(wiper1) |-> sck_seen) else $error("wiper1 moved without sck");
   AST_TC_ON_SCK: assert property ($changed(terminal_connect_control) |-> sck_seen) else $error("terminal control moved");
   AST_W0_SAT: assert property ($past(wiper0) >= FULL_SCALE |-> wiper0 != $past(wiper0) + 9'h001) else $error("w0 sat");
   AST_W1_SAT: assert property ($past(wiper1) >= FULL_SCALE |-> wiper1 != $past(wiper1) + 9'h001) else $error("w1 sat");
endmodule
bind pot_spi_command_engine pot_spi_command_engine_checks #(.FULL_SCALE(FULL_SCALE), .NV_WRITE_CYCLES(NV_WRITE_CYCLES))
   chk (
      .clock                    (clock),
      .rstn                     (rstn),
      .cs_n                     (cs_n),
      .sck                      (sck),
      .sdi                      (sdi),
      .sdo                      (sdo),
      .sdo_oe_n                 (sdo_oe_n),
      .wiper0                   (wiper0),
      .wiper1                   (wiper1),
      .terminal_connect_control (terminal_connect_control),
      .nv_write_active          (nv_write_active)
   );

// [testbench/spi_host.sv]
`timescale 1ns/1ps
module spi_host (
   output logic      cs_n,
   output logic      sck,
   output logic      sdi,
   input  wire logic sdo
);
   initial begin
      cs_n = 1'b1;
      sck  = 1'b0;
      sdi  = 1'b1;
   end
   // Mode 0; sck stands low between frames, device output taken on the rise
   task automatic shift(input logic [15:0] w, input int n, output logic [15:0] got);
      got = 16'h0000;
      for (int i = n - 1; i >= 0; i--) begin
         sdi = w[i];
         #62.5 sck = 1'b1;
         got = {got[14:0], sdo};
         #62.5 sck = 1'b0;
      end
   endtask
   // Data idles high only between selects, so back-to-back frames touch sdi once per step
   task automatic sel(input logic v);
      sdi = 1'b1;
      #250 cs_n = v;
   endtask
endmodule

// [testbench/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
   logic       clock = 1'b0;
   logic       rstn  = 1'b0;
   logic       cs_n, sck, sdi;
   wire        sdo, sdo_oe_n, nv_write_active;
   wire  [8:0] wiper0, wiper1, terminal_connect_control;
   logic [15:0] got;
   logic [9:0] res;
   logic [9:0] q[$];
   logic [7:0] lf = 8'h62;
   int         miscompares = 0;
   int         checked = 0;
   event       res_ev;
   spi_host h (
      .cs_n (cs_n),
      .sck  (sck),
      .sdi  (sdi),
      .sdo  (sdo)
   );
   pot_spi_command_engine #(.NV_WRITE_CYCLES(2000)) dut (
      .clock                    (clock),
      .rstn                     (rstn),
      .cs_n                     (cs_n),
      .sck                      (sck),
      .sdi                      (sdi),
      .sdo                      (sdo),
      .sdo_oe_n                 (sdo_oe_n),
      .wiper0                   (wiper0),
      .wiper1                   (wiper1),
      .terminal_connect_control (terminal_connect_control),
      .nv_write_active          (nv_write_active)
   );
   initial begin
      forever #5 clock = ~clock;
   end
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   task automatic end_of_test;
      $display("compares %0d mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // Answer word: flag taken at the seventh rise, then nine data bits
   task automatic f16(input logic [3:0] a, input logic [1:0] c, input logic [9:0] d, input logic [9:0] e);
      q.push_back(e);
      h.shift({a, c, d}, 16, got);
      res = got[9:0];
      -> res_ev;
   endtask
   task automatic f8(input logic [3:0] a, input logic [1:0] c, input logic e);
      q.push_back({e, 9'h000});
      h.shift({8'h00, a, c, 2'b11}, 8, got);
      res = {got[1], 9'h000};
      -> res_ev;
   endtask
   task automatic cmp_word(input logic [9:0] exp, input logic [9:0] seen);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] sdo_word expected %h seen %h", exp, seen);
      end
   endtask
   task automatic chk_pin(input string name, input logic [8:0] exp, input logic [8:0] seen);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   initial begin
      forever begin
         @(res_ev);
         cmp_word(q[0], res);
         void'(q.pop_front());
      end
   end
   initial begin
      #300000;
      miscompares++;
      end_of_test;
   end
   initial begin
      repeat (6) @(posedge clock);
      #1 rstn = 1'b1;
      for (int i = 0; i < 3; i++) begin
         lf = lfsr(lf);
         h.sel(1'b0);
         f16(4'h0, 2'h0, {2'b00, lf}, 10'h3ff);
         f8(4'h0, 2'h1, 1'b1);
         chk_pin("wiper0", {1'b0, lf} + 9'h001, wiper0);
         f16(4'h0, 2'h3, 10'h3ff, {2'b10, lf} + 10'h001);
         h.sel(1'b1);
      end
      h.sel(1'b0);
      f16(4'h1, 2'h0, 10'h0ff, 10'h3ff);
      f16(4'h0, 2'h0, 10'h150, 10'h3ff);
      f8(4'h1, 2'h1, 1'b1);
      f8(4'h1, 2'h1, 1'b1);
      chk_pin("wiper1", 9'h100, wiper1);
      f8(4'h0, 2'h1, 1'b1);
      chk_pin("wiper0", 9'h150, wiper0);
      f16(4'h1, 2'h3, 10'h3ff, 10'h300);
      f16(4'h0, 2'h3, 10'h3ff, 10'h350);
      f8(4'h0, 2'h2, 1'b0);
      f16(4'h0, 2'h3, 10'h3ff, 10'h000);
      h.sel(1'b1);
      h.sel(1'b0);
      f16(4'h2, 2'h0, 10'h1a5, 10'h3ff);
      h.sel(1'b1);
      h.sel(1'b0);
      chk_pin("nv_write_active", 9'h001, {8'h00, nv_write_active});
      f16(4'h4, 2'h3, 10'h3ff, 10'h201);
      f16(4'h5, 2'h0, 10'h0aa, 10'h3ff);
      chk_pin("terminal_connect_control", 9'h0aa, terminal_connect_control);
      chk_pin("sdo_oe_n", 9'h000, {8'h00, sdo_oe_n});
      f16(4'h5, 2'h3, 10'h3ff, 10'h2aa);
      f16(4'h2, 2'h3, 10'h3ff, 10'h000);
      h.sel(1'b1);
      repeat (2100) @(posedge clock);
      // Step off the edge so the next select does not land on a sampling edge
      #1;
      chk_pin("nv_write_active", 9'h000, {8'h00, nv_write_active});
      chk_pin("sdo_oe_n", 9'h001, {8'h00, sdo_oe_n});
      h.sel(1'b0);
      f16(4'h4, 2'h3, 10'h3ff, 10'h200);
      f16(4'h2, 2'h3, 10'h3ff, 10'h3a5);
      f16(4'h3, 2'h0, 10'h0c3, 10'h3ff);
      f16(4'h3, 2'h0, 10'h0c3, 10'h000);
      h.sel(1'b1);
      h.sel(1'b0);
      f16(4'h3, 2'h3, 10'h3ff, 10'h200);
      h.shift({1'b0, 4'h3, 2'h0, 9'h0c3}, 15, got);
      h.sel(1'b1);
      h.sel(1'b0);
      f16(4'h4, 2'h3, 10'h3ff, 10'h200);
      h.sel(1'b1);
      end_of_test;
   end
endmodule
